// >>> hbp_pkg.sv
package hbp_pkg;
    // sizes
    localparam int NUM_BRIDGES = 3;
    localparam int DLY_W = 8;
    localparam int CODE_W = 6;
    localparam int TMR_W = 16;
    localparam int CNT_W = 5;
    localparam int FLIP_W = 2;
    localparam int ADDR_W = 6;
    localparam int SYNC_W = 9;

    // regulation thresholds and counter limits
    localparam logic [CNT_W-1:0] REG_THRESH = 5'h08;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
    localparam logic [FLIP_W-1:0] FLIP_THRESH = 2'h3;
    localparam logic [TMR_W-1:0] TMR_MAX = 16'hFFFF;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_MODE = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_TON = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_TOFF = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_CHG = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_PCHG = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_CCP = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_TMO = 6'h1C;
    localparam logic [ADDR_W-1:0] OFF_STAT = 6'h20;

    // register field positions
    localparam int CTRL_SIX_BIT = 0;
    localparam int CTRL_DETECT_BIT = 1;
    localparam int CTRL_POCHG_BIT = 2;
    localparam int CTRL_AGC_LSB = 4;
    localparam int CTRL_EN_LSB = 8;
    localparam int CCP_FW_LSB = 16;
    localparam int STAT_UP_LSB = 4;
    localparam int STAT_DN_LSB = 8;
    localparam int STAT_DET_LSB = 12;

    // writable masks
    localparam logic [31:0] MASK_CTRL = 32'h0000_0737;
    localparam logic [31:0] MASK_MODE = 32'h0000_003F;
    localparam logic [31:0] MASK_DLY = 32'h00FF_FFFF;
    localparam logic [31:0] MASK_CODE = 32'h0003_FFFF;
    localparam logic [31:0] MASK_CCP = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_TMO = 32'h0000_FFFF;

    // bridge operating modes
    localparam logic [1:0] MODE_PASSIVE = 2'h0;
    localparam logic [1:0] MODE_LOWER_ACT = 2'h1;
    localparam logic [1:0] MODE_UPPER_ACT = 2'h2;
    localparam logic [1:0] MODE_HOLD_OFF = 2'h3;

    // adaptive gate settings
    localparam logic [1:0] AGC_SEQ_A = 2'h1;
    localparam logic [1:0] AGC_SEQ_B = 2'h2;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CCP_ACTIVE_NS = 500;
    localparam int CCP_FW_NS = 500;
    localparam int OFF_TIMEOUT_NS = 2000;
    localparam logic [TMR_W-1:0] CCP_ACTIVE_CYC = TMR_W'((CCP_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] CCP_FW_CYC = TMR_W'((CCP_FW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] OFF_TIMEOUT_CYC = TMR_W'(OFF_TIMEOUT_NS / CLK_PERIOD_NS);

    // reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_MODE = 32'h0000_0000;
    localparam logic [31:0] RST_DLY = 32'h0000_0000;
    localparam logic [31:0] RST_CODE = 32'h0000_0000;
    localparam logic [31:0] RST_CCP = {CCP_FW_CYC, CCP_ACTIVE_CYC};
    localparam logic [31:0] RST_TMO = {16'h0000, OFF_TIMEOUT_CYC};

    typedef enum logic [2:0] {ST_IDLE, ST_UP_PEND, ST_UP_ON, ST_DN_PEND, ST_DN_ON} hbp_state_t;
endpackage

// >>> hbp_sync.sv
`timescale 1ns/1ps
module hbp_sync #(
    parameter int W = 9
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    import hbp_pkg::*;

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // two-stage synchroniser
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// >>> hbp_reg_track.sv
`timescale 1ns/1ps
module hbp_reg_track (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic enable,
    input wire logic sample,
    input wire logic [hbp_pkg::DLY_W-1:0] meas_on,
    input wire logic [hbp_pkg::DLY_W-1:0] targ_on,
    input wire logic [hbp_pkg::DLY_W-1:0] meas_off,
    input wire logic [hbp_pkg::DLY_W-1:0] targ_off,
    output logic regulated
);
    import hbp_pkg::*;

    logic [CNT_W-1:0] on_cnt_ff;
    logic [CNT_W-1:0] off_cnt_ff;
    logic [FLIP_W-1:0] on_flip_ff;
    logic [FLIP_W-1:0] off_flip_ff;
    logic on_sign_ff;
    logic off_sign_ff;
    logic on_seen_ff;
    logic off_seen_ff;
    logic regulated_ff;

    // saturating up on match, down otherwise
    function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c, input logic hit);
        if (hit) begin
            step = (c == CNT_MAX) ? c : c + 5'h01;
        end else begin
            step = (c == '0) ? c : c - 5'h01;
        end
    endfunction

    // consecutive error sign changes
    function automatic logic [FLIP_W-1:0] flips(input logic [FLIP_W-1:0] f, input logic seen,
                                                input logic sgn, input logic [DLY_W-1:0] m,
                                                input logic [DLY_W-1:0] t);
        if (m == t) begin
            flips = f;
        end else if (seen && ((m > t) != sgn)) begin
            flips = (f == FLIP_THRESH) ? f : f + 2'h1;
        end else begin
            flips = '0;
        end
    endfunction

    // R11 delay match counters
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            on_cnt_ff <= '0;
            off_cnt_ff <= '0;
        end else if (clear || !enable) begin
            on_cnt_ff <= '0;
            off_cnt_ff <= '0;
        end else if (sample) begin
            on_cnt_ff <= step(on_cnt_ff, meas_on == targ_on);
            off_cnt_ff <= step(off_cnt_ff, meas_off == targ_off);
        end
    end

    // R13 error sign history
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            on_flip_ff <= '0;
            off_flip_ff <= '0;
            on_sign_ff <= 1'b0;
            off_sign_ff <= 1'b0;
            on_seen_ff <= 1'b0;
            off_seen_ff <= 1'b0;
        end else if (clear || !enable) begin
            on_flip_ff <= '0;
            off_flip_ff <= '0;
            on_seen_ff <= 1'b0;
            off_seen_ff <= 1'b0;
        end else if (sample) begin
            on_flip_ff <= flips(on_flip_ff, on_seen_ff, on_sign_ff, meas_on, targ_on);
            off_flip_ff <= flips(off_flip_ff, off_seen_ff, off_sign_ff, meas_off, targ_off);
            if (meas_on != targ_on) begin
                on_sign_ff <= meas_on > targ_on;
                on_seen_ff <= 1'b1;
            end
            if (meas_off != targ_off) begin
                off_sign_ff <= meas_off > targ_off;
                off_seen_ff <= 1'b1;
            end
        end
    end

    // R12 either condition declares regulation
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regulated_ff <= 1'b0;
        end else begin
            regulated_ff <= enable && !clear &&
                ((on_cnt_ff >= REG_THRESH && off_cnt_ff >= REG_THRESH) ||
                 (on_flip_ff == FLIP_THRESH && off_flip_ff == FLIP_THRESH));
        end
    end

    assign regulated = regulated_ff;
endmodule

// >>> hbp_bridge_ctrl.sv
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Functional notes
// R1 - bridge two decodes inputs three and four.
// R2 - bridge three decodes inputs five and six.
// R3 - freewheeling lower goes off before upper turns on.
// R4 - upper edge before off-timeout: hard-off lower, then upper on; the hard-off pulse rises in the same cycle as upper on.
// R5 - early upper edge ignored until freewheel window ends.
// R6 - active upper goes off before freewheeling lower turns on.
// R7 - early lower edge ignored until active window ends.
// R8 - detection off, mode 10: upper is active.
// R9 - detection on: detected side is active.
// R10 - regulation flag per bridge, adaptive setting 10 or 11.
// R11 - delay counters step up on match, down otherwise.
// R12 - regulated when both counters reach eight.
// R13 - or after three consecutive error sign changes.
// R14 - 6-bit charge and precharge codes per bridge.
// R15 - six-input mode and enable: each switch from its own input.
// R16 - mode 00 passive off, mode 11 held off.
// R17 - bridge one decodes inputs one and two.
// R18 - inputs synchronised; tracking clears on reconfiguration.
module hbp_bridge_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [hbp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pulse_input_one,
    input wire logic pulse_input_two,
    input wire logic pulse_input_three,
    input wire logic pulse_input_four,
    input wire logic pulse_input_five,
    input wire logic pulse_input_six,
    input wire logic [hbp_pkg::NUM_BRIDGES-1:0] upper_active_detected,
    input wire logic [hbp_pkg::NUM_BRIDGES-1:0] delay_sample_valid,
    input wire logic [hbp_pkg::NUM_BRIDGES*hbp_pkg::DLY_W-1:0] measured_turnon_delay,
    input wire logic [hbp_pkg::NUM_BRIDGES*hbp_pkg::DLY_W-1:0] measured_turnoff_delay,
    output logic [hbp_pkg::NUM_BRIDGES-1:0] upper_switch_on,
    output logic [hbp_pkg::NUM_BRIDGES-1:0] lower_switch_on,
    output logic [hbp_pkg::NUM_BRIDGES-1:0] hard_turnoff_current,
    output logic [hbp_pkg::NUM_BRIDGES-1:0] active_hold_off,
    output logic [hbp_pkg::NUM_BRIDGES-1:0] passive_discharge,
    output logic [hbp_pkg::NUM_BRIDGES-1:0] post_charge_on,
    output logic [hbp_pkg::NUM_BRIDGES-1:0] delay_regulated_flag,
    output logic [hbp_pkg::NUM_BRIDGES*hbp_pkg::CODE_W-1:0] charge_current_code,
    output logic [hbp_pkg::NUM_BRIDGES*hbp_pkg::CODE_W-1:0] initial_precharge_code
);
    import hbp_pkg::*;

    logic [31:0] ctrl_ff;
    logic [31:0] mode_ff;
    logic [31:0] ton_ff;
    logic [31:0] toff_ff;
    logic [31:0] chg_ff;
    logic [31:0] pchg_ff;
    logic [31:0] ccp_ff;
    logic [31:0] tmo_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic wr_fire;
    logic [SYNC_W-1:0] sync_vec;
    logic [NUM_BRIDGES-1:0] regulated;
    logic [NUM_BRIDGES-1:0] upper_on_ff;
    logic [NUM_BRIDGES-1:0] lower_on_ff;
    logic [NUM_BRIDGES-1:0] hard_off_ff;
    logic [NUM_BRIDGES-1:0] hold_off_ff;
    logic [NUM_BRIDGES-1:0] passive_ff;
    logic [NUM_BRIDGES-1:0] pochg_ff;
    logic [NUM_BRIDGES-1:0] flag_ff;

    logic six_mode;
    logic detect_en;
    logic pochg_allowed;
    logic [1:0] adaptive_gate_setting;
    logic adaptive_on;
    logic [TMR_W-1:0] win_active;
    logic [TMR_W-1:0] win_fw;
    logic [TMR_W-1:0] off_timeout;

    // byte-lane masked write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i+:8] = wd[8*i+:8];
            end
        end
        merge = res & mask;
    endfunction

    // own input high, partner low
    function automatic logic want(input logic own, input logic other);
        want = own && !other;
    endfunction

    // R18 synchronise pulse and detection inputs
    hbp_sync #(
        .W(SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({upper_active_detected, pulse_input_six, pulse_input_five,
                   pulse_input_four, pulse_input_three, pulse_input_two, pulse_input_one}),
        .sync_out(sync_vec)
    );

    // configuration fields
    assign six_mode = ctrl_ff[CTRL_SIX_BIT];
    assign detect_en = ctrl_ff[CTRL_DETECT_BIT];
    assign adaptive_gate_setting = ctrl_ff[CTRL_AGC_LSB+:2];
    assign pochg_allowed = !ctrl_ff[CTRL_POCHG_BIT] && (adaptive_gate_setting == AGC_SEQ_A || adaptive_gate_setting == AGC_SEQ_B);
    // R10 adaptive setting 10 or 11
    assign adaptive_on = adaptive_gate_setting[1];
    assign win_active = ccp_ff[TMR_W-1:0];
    assign win_fw = ccp_ff[CCP_FW_LSB+:TMR_W];
    assign off_timeout = tmo_ff[TMR_W-1:0];

    // one wait cycle, then waitrequest low for one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= wait_ff ? !(avs_read || avs_write) : 1'b1;
        end
    end

    assign wr_fire = avs_write && !wait_ff;

    // read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (avs_address)
            OFF_CTRL: nxt_rdata = ctrl_ff;
            OFF_MODE: nxt_rdata = mode_ff;
            OFF_TON: nxt_rdata = ton_ff;
            OFF_TOFF: nxt_rdata = toff_ff;
            OFF_CHG: nxt_rdata = chg_ff;
            OFF_PCHG: nxt_rdata = pchg_ff;
            OFF_CCP: nxt_rdata = ccp_ff;
            OFF_TMO: nxt_rdata = tmo_ff;
            OFF_STAT: begin
                nxt_rdata[NUM_BRIDGES-1:0] = flag_ff;
                nxt_rdata[STAT_UP_LSB+:NUM_BRIDGES] = upper_on_ff;
                nxt_rdata[STAT_DN_LSB+:NUM_BRIDGES] = lower_on_ff;
                nxt_rdata[STAT_DET_LSB+:NUM_BRIDGES] = sync_vec[SYNC_W-1-:NUM_BRIDGES];
            end
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // read data captured in the wait cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read && wait_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= RST_CTRL;
            mode_ff <= RST_MODE;
            ton_ff <= RST_DLY;
            toff_ff <= RST_DLY;
            chg_ff <= RST_CODE;
            pchg_ff <= RST_CODE;
            ccp_ff <= RST_CCP;
            tmo_ff <= RST_TMO;
        end else if (wr_fire) begin
            case (avs_address)
                OFF_CTRL: ctrl_ff <= merge(ctrl_ff, avs_writedata, avs_byteenable, MASK_CTRL);
                OFF_MODE: mode_ff <= merge(mode_ff, avs_writedata, avs_byteenable, MASK_MODE);
                OFF_TON: ton_ff <= merge(ton_ff, avs_writedata, avs_byteenable, MASK_DLY);
                OFF_TOFF: toff_ff <= merge(toff_ff, avs_writedata, avs_byteenable, MASK_DLY);
                OFF_CHG: chg_ff <= merge(chg_ff, avs_writedata, avs_byteenable, MASK_CODE);
                OFF_PCHG: pchg_ff <= merge(pchg_ff, avs_writedata, avs_byteenable, MASK_CODE);
                OFF_CCP: ccp_ff <= merge(ccp_ff, avs_writedata, avs_byteenable, MASK_CCP);
                OFF_TMO: tmo_ff <= merge(tmo_ff, avs_writedata, avs_byteenable, MASK_TMO);
                default: ;
            endcase
        end
    end

    // per-bridge sequencing
    for (genvar b = 0; b < NUM_BRIDGES; b++) begin : g_hb
        logic in_up;
        logic in_dn;
        logic [1:0] mode;
        logic en;
        logic upper_act;
        logic want_up;
        logic want_dn;
        logic [TMR_W-1:0] up_win;
        logic [TMR_W-1:0] dn_win;
        logic up_ok;
        logic dn_ok;
        hbp_state_t st_ff;
        hbp_state_t nxt_st;
        logic [TMR_W-1:0] since_off_ff;
        logic last_lower_ff;
        logic [3:0] cfg_prev_ff;
        logic cfg_clear;

        // R1 R2 R17 input pair of this bridge
        assign in_up = sync_vec[2*b];
        assign in_dn = sync_vec[2*b+1];
        assign mode = mode_ff[2*b+:2];
        // R15 bridge enabled
        assign en = six_mode && ctrl_ff[CTRL_EN_LSB+b] &&
                    (mode == MODE_LOWER_ACT || mode == MODE_UPPER_ACT);
        // R8 R9 choose which switch is active
        assign upper_act = detect_en ? sync_vec[2*NUM_BRIDGES+b] : (mode == MODE_UPPER_ACT);
        // R1 R2 R17 decode, equal inputs keep both off
        assign want_up = want(in_up, in_dn);
        assign want_dn = want(in_dn, in_up);
        // R5 R7 windows count from last switch-off
        assign up_win = upper_act ? win_fw : win_active;
        assign dn_win = upper_act ? win_active : win_fw;
        assign up_ok = since_off_ff >= up_win;
        assign dn_ok = since_off_ff >= dn_win;

        // R3 R6 one on-state is left before the other
        always_comb begin
            nxt_st = st_ff;
            if (!en) begin
                nxt_st = ST_IDLE;
            end else begin
                case (st_ff)
                    ST_IDLE, ST_UP_PEND, ST_DN_PEND: begin
                        if (want_up) begin
                            nxt_st = up_ok ? ST_UP_ON : ST_UP_PEND;
                        end else if (want_dn) begin
                            nxt_st = dn_ok ? ST_DN_ON : ST_DN_PEND;
                        end else begin
                            nxt_st = ST_IDLE;
                        end
                    end
                    ST_UP_ON: begin
                        if (!want_up) begin
                            nxt_st = want_dn ? ST_DN_PEND : ST_IDLE;
                        end
                    end
                    ST_DN_ON: begin
                        if (!want_dn) begin
                            nxt_st = want_up ? ST_UP_PEND : ST_IDLE;
                        end
                    end
                    default: nxt_st = ST_IDLE;
                endcase
            end
        end

        // state and off-time counter
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                st_ff <= ST_IDLE;
                since_off_ff <= TMR_MAX;
                last_lower_ff <= 1'b0;
            end else begin
                st_ff <= nxt_st;
                if (st_ff == ST_UP_ON || st_ff == ST_DN_ON) begin
                    since_off_ff <= '0;
                    last_lower_ff <= (st_ff == ST_DN_ON);
                end else if (since_off_ff != TMR_MAX) begin
                    since_off_ff <= since_off_ff + 16'h0001;
                end
            end
        end

        // registered gate outputs
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                upper_on_ff[b] <= 1'b0;
                lower_on_ff[b] <= 1'b0;
                hard_off_ff[b] <= 1'b0;
                pochg_ff[b] <= 1'b0;
            end else begin
                upper_on_ff[b] <= (nxt_st == ST_UP_ON);
                lower_on_ff[b] <= (nxt_st == ST_DN_ON);
                // R4 hard-off pulse on upper edge before off-timeout
                hard_off_ff[b] <= (nxt_st == ST_UP_ON) && (st_ff != ST_UP_ON) &&
                                  upper_act && last_lower_ff && (since_off_ff < off_timeout);
                pochg_ff[b] <= pochg_allowed && (nxt_st == ST_UP_ON || nxt_st == ST_DN_ON);
            end
        end

        // R16 off modes regardless of pulse enable
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                hold_off_ff[b] <= 1'b0;
                passive_ff[b] <= 1'b1;
            end else begin
                hold_off_ff[b] <= six_mode && (mode == MODE_HOLD_OFF);
                passive_ff[b] <= !six_mode || (mode == MODE_PASSIVE);
            end
        end

        // R18 config change clears tracking
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                cfg_prev_ff <= 4'h0;
            end else begin
                cfg_prev_ff <= {adaptive_gate_setting, mode};
            end
        end

        assign cfg_clear = (cfg_prev_ff != {adaptive_gate_setting, mode});

        // R11 R12 R13 regulation tracking
        hbp_reg_track u_track (
            .sys_clk(sys_clk),
            .rst(rst),
            .clear(cfg_clear),
            .enable(adaptive_on),
            .sample(delay_sample_valid[b]),
            .meas_on(measured_turnon_delay[DLY_W*b+:DLY_W]),
            .targ_on(ton_ff[DLY_W*b+:DLY_W]),
            .meas_off(measured_turnoff_delay[DLY_W*b+:DLY_W]),
            .targ_off(toff_ff[DLY_W*b+:DLY_W]),
            .regulated(regulated[b])
        );
    end

    // R10 per-bridge regulation flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= regulated & {NUM_BRIDGES{adaptive_on}};
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign upper_switch_on = upper_on_ff;
    assign lower_switch_on = lower_on_ff;
    assign hard_turnoff_current = hard_off_ff;
    assign active_hold_off = hold_off_ff;
    assign passive_discharge = passive_ff;
    assign post_charge_on = pochg_ff;
    assign delay_regulated_flag = flag_ff;
    // R14 current codes
    assign charge_current_code = chg_ff[NUM_BRIDGES*CODE_W-1:0];
    assign initial_precharge_code = pchg_ff[NUM_BRIDGES*CODE_W-1:0];
endmodule

// >>> hbp_chk_properties.sv
`timescale 1ns/1ps
module hbp_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pulse_input_one,
    input wire logic pulse_input_two,
    input wire logic pulse_input_three,
    input wire logic pulse_input_four,
    input wire logic [2:0] upper_switch_on,
    input wire logic [2:0] lower_switch_on,
    input wire logic [2:0] hard_turnoff_current,
    input wire logic [2:0] active_hold_off,
    input wire logic [2:0] passive_discharge,
    input wire logic [2:0] delay_regulated_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // gate commands
    no_overlap_a: assert property ((upper_switch_on & lower_switch_on) == 3'h0)
        else $error("both switches on");
    hold_off_a: assert property ((active_hold_off & (upper_switch_on | lower_switch_on)) == 3'h0)
        else $error("switch on in hold-off");
    passive_off_a: assert property ((passive_discharge & (upper_switch_on | lower_switch_on)) == 3'h0)
        else $error("switch on in passive mode");
    swap_gap_a: assert property (((upper_switch_on & $past(lower_switch_on)) |
        (lower_switch_on & $past(upper_switch_on))) == 3'h0) else $error("direct swap");
    // decoded pin pair
    one_up_a: assert property ($rose(upper_switch_on[0]) |->
        $past(pulse_input_one, 3) && !$past(pulse_input_two, 3)) else $error("bad upper one");
    two_dn_a: assert property ($rose(lower_switch_on[1]) |->
        !$past(pulse_input_three, 3) && $past(pulse_input_four, 3)) else $error("bad lower two");
    // single hard-off pulse
    hard_up_a: assert property (hard_turnoff_current[0] |-> ##[0:2] upper_switch_on[0])
        else $error("hard-off without upper on");
    hard_one_a: assert property ((hard_turnoff_current & $past(hard_turnoff_current)) == 3'h0)
        else $error("hard-off too long");
    // main scenarios reached
    cover property ($rose(upper_switch_on[0]));
    cover property (hard_turnoff_current[0]);
    cover property ($rose(delay_regulated_flag[1]));
endmodule
bind hbp_bridge_ctrl hbp_chk hbp_chk_i (.sys_clk, .rst, .pulse_input_one, .pulse_input_two,
    .pulse_input_three, .pulse_input_four, .upper_switch_on, .lower_switch_on,
    .hard_turnoff_current, .active_hold_off, .passive_discharge, .delay_regulated_flag);

// >>> hbp_host.sv
`timescale 1ns/1ps
module hbp_host (
    input wire logic sys_clk,
    input wire logic [1:0] pair_req,
    output logic [5:0] pins
);
    // same pin pair on every bridge
    initial pins = 6'h00;
    always @(posedge sys_clk) begin
        pins <= {3{pair_req}};
    end
endmodule

// >>> test_six_input_half_bridge_pwm_control.sv
`timescale 1ns/1ps
module test_six_input_half_bridge_pwm_control;
    import hbp_pkg::*;
    logic sys_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address, pins;
    logic [31:0] avs_writedata, avs_readdata, rnd, rd_q[$];
    logic [1:0] pair_req;
    logic [2:0] smp_vld, det;
    logic [23:0] m_on, m_off;
    int err_total = 0, num_checks = 0, cyc = 0;
    hbp_host hbp_host_i (.sys_clk, .pair_req, .pins);
    hbp_bridge_ctrl hbp_bridge_ctrl_i (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .pulse_input_one(pins[1]), .pulse_input_two(pins[0]), .pulse_input_three(pins[3]),
        .pulse_input_four(pins[2]), .pulse_input_five(pins[5]), .pulse_input_six(pins[4]),
        .upper_active_detected(det), .delay_sample_valid(smp_vld),
        .measured_turnon_delay(m_on), .measured_turnoff_delay(m_off), .upper_switch_on(),
        .lower_switch_on(), .hard_turnoff_current(), .active_hold_off(), .passive_discharge(),
        .post_charge_on(), .delay_regulated_flag(), .charge_current_code(),
        .initial_precharge_code());
    // clock and timeout
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one bus access; a read notes its expected word
    task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        if (!wr) rd_q.push_back(d);
        tick(1);
        while (avs_waitrequest !== 1'b0) tick(1);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        tick(1);
    endtask
    // read answers against the oldest note
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
            num_checks++;
            if (avs_readdata !== rd_q[0]) begin
                err_total++;
                $display("Error %0t: read %h expected %h", $time, avs_readdata, rd_q[0]);
            end
            void'(rd_q.pop_front());
        end
    end
    // expected status word
    function automatic logic [31:0] st(input logic [1:0] m, input logic [1:0] p);
        logic en;
        en = (m == MODE_LOWER_ACT) || (m == MODE_UPPER_ACT);
        return {21'h0, {3{en && p == 2'h1}}, 1'b0, {3{en && p == 2'h2}}, 4'h0};
    endfunction
    // one measurement pulse, delays off target by d; flag lags two cycles
    task automatic samp(input logic [7:0] d);
        m_on <= {3{8'h05 + d}};
        m_off <= {3{8'h07 + d}};
        smp_vld <= 3'h7;
        tick(1);
        smp_vld <= 3'h0;
        tick(2);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 40'h0};
        {det, pair_req, smp_vld, m_on, m_off} = 56'h0;
        void'($urandom(32'h201D584B));
        tick(4);
        rst <= 1'b0;
        tick(1);
        acc(0, OFF_CCP, RST_CCP);
        acc(0, OFF_STAT, 32'h0);
        acc(0, 6'h3C, 32'h0);
        rnd = $urandom;
        acc(1, OFF_CHG, rnd);
        acc(0, OFF_CHG, rnd & MASK_CODE);
        acc(1, OFF_CCP, 32'h0004_0004);
        acc(1, OFF_CTRL, 32'h0000_0721);
        for (int m = 0; m < 4; m++) begin
            acc(1, OFF_MODE, {26'h0, {3{m[1:0]}}});
            for (int p = 0; p < 4; p++) begin
                pair_req <= p[1:0];
                tick(20);
                acc(0, OFF_STAT, st(m[1:0], p[1:0]));
            end
        end
        acc(1, OFF_CCP, 32'h0028_0028);
        acc(1, OFF_MODE, 32'h0000_002A);
        pair_req <= 2'h1;
        tick(20);
        pair_req <= 2'h2;
        tick(15);
        acc(0, OFF_STAT, 32'h0);
        tick(40);
        acc(0, OFF_STAT, 32'h70);
        pair_req <= 2'h1;
        tick(15);
        acc(0, OFF_STAT, 32'h0);
        tick(40);
        acc(1, OFF_TON, 32'h0005_0505);
        acc(1, OFF_TOFF, 32'h0007_0707);
        repeat (7) samp(8'h00);
        acc(0, OFF_STAT, 32'h700);
        samp(8'h00);
        acc(0, OFF_STAT, 32'h707);
        samp(8'($urandom) | 8'h01);
        acc(0, OFF_STAT, 32'h700);
        samp(8'h00);
        acc(0, OFF_STAT, 32'h707);
        acc(1, OFF_CTRL, 32'h0000_0711);
        acc(1, OFF_CTRL, 32'h0000_0721);
        acc(0, OFF_STAT, 32'h700);
        repeat (2) begin
            samp(8'h01);
            samp(8'hFF);
        end
        acc(0, OFF_STAT, 32'h707);
        det <= 3'h7;
        acc(1, OFF_CCP, 32'h0028_0004);
        acc(1, OFF_CTRL, 32'h0000_0723);
        acc(1, OFF_MODE, 32'h0000_0015);
        pair_req <= 2'h2;
        tick(15);
        acc(0, OFF_STAT, 32'h7000);
        stop_test();
    end
endmodule
